// *** hw/qirwc_defs.svh ***
// Constants of the quad I/O read block: command codes, field positions,
// reset values and clock counts. Included by the package and both ends.
`ifndef QIRWC_DEFS_SVH
`define QIRWC_DEFS_SVH

// ==========================================================
// Command codes
`define QIRWC_CMD_FAST 8'hEB
`define QIRWC_CMD_WORD 8'hE7
`define QIRWC_CMD_OCTAL 8'hE3
`define QIRWC_CMD_WRAP 8'h77
`define QIRWC_CMD_MODE_RESET 8'hFF

// ==========================================================
// Field positions and values
`define QIRWC_CONT_SEL_HI 5
`define QIRWC_CONT_SEL_LO 4
`define QIRWC_CONT_SEL_ON 2'h2
`define QIRWC_WRAP_DIS_POS 4
`define QIRWC_WRAP_LEN_HI 6
`define QIRWC_WRAP_LEN_LO 5
`define QIRWC_WRAP_DIS_RST 1'h1
`define QIRWC_WRAP_LEN_RST 2'h0
`define QIRWC_PAGE_BITS 8
`define QIRWC_SECTION_MIN 8'h08

// ==========================================================
// Clock counts
`define QIRWC_CMD_CLKS 8
`define QIRWC_QIN_CLKS 8
`define QIRWC_DUMMY_FAST 3'h4
`define QIRWC_DUMMY_WORD 3'h2
`define QIRWC_DUMMY_OCTAL 3'h0

`endif

// *** hw/qirwc_pkg.sv ***
// Types and shared decode of the quad I/O read block.
// Assumes qirwc_defs.svh is on the include path.
`include "qirwc_defs.svh"

package qirwc_pkg;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    DEV_IDLE,
    DEV_CMD,
    DEV_QIN,
    DEV_DUMMY,
    DEV_DATA,
    DEV_IGNORE
  } qirwc_dev_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE,
    HOST_SETUP,
    HOST_RUN,
    HOST_GAP,
    HOST_END
  } qirwc_host_state_t;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRAP,
    OP_MODE_RESET
  } qirwc_op_t;

  // ==========================================================
  // Dummy clocks that follow the mode byte of each read code
  function automatic logic [2:0] qirwc_dummy_of(input logic [7:0] code);
    if (code == `QIRWC_CMD_FAST) begin
      return `QIRWC_DUMMY_FAST;
    end else if (code == `QIRWC_CMD_WORD) begin
      return `QIRWC_DUMMY_WORD;
    end
    return `QIRWC_DUMMY_OCTAL;
  endfunction

endpackage

// *** hw/qirwc_if.sv ***
// Serial link between the flash controller and the flash read logic.
// Both ends run on the same ref_clk; lanes resolve here with a pull-up.
interface qirwc_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_lane_o;
  logic [3:0] host_lane_oe;
  logic [3:0] dev_lane_o;
  logic [3:0] dev_lane_oe;
  logic [3:0] lane;

  // ==========================================================
  // Wire resolution
  // An undriven lane reads high, as a weak pull-up would hold it.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_lane_oe[i]) begin
        lane[i] = dev_lane_o[i];
      end else if (host_lane_oe[i]) begin
        lane[i] = host_lane_o[i];
      end else begin
        lane[i] = 1'h1;
      end
    end
  end

  modport host (output sclk, output cs_n, output host_lane_o, output host_lane_oe, input lane);
  modport dev (input sclk, input cs_n, input lane, output dev_lane_o, output dev_lane_oe);
endinterface

// *** hw/qirwc_flash_dev.sv ***
// Read-command logic of the serial flash for its quad I/O reads.
// Assumes sclk and cs_n come from logic on the same ref_clk.
//
// Notes on behaviour
// - Wrap confines data to page section.
// - Start at address, wrap to section base.
// - Wrap setting persists for later reads.
// - Hold wrap-disable bit and length field.
// - Host gives even address for word read.
// - Word read has two dummy clocks.
// - Word read needs quad-enable set.
// - Host gives 16-aligned address, octal read.
// - Octal read has no dummy clocks.
// - Octal read needs quad-enable set.
// - Mode byte follows address; low nibble ignored.
// - Select bits 10 skip next command code.
// - Other select bits need full code.
// - Code skipping also applies to octal read.
// - Host releases lanes before data out.
// - Reset instruction leaves continuous mode.
// - Reset is eight quad or sixteen dual ones.
// - Wrap disabled at power-on.
// - Wrap set: code, 24 dummy, wrap byte.
// - Fast quad read has four dummy clocks.
//
// Added by the designer: the address map and the plain strobed port.
`include "qirwc_defs.svh"

module qirwc_flash_dev #(
  parameter int MEM_AW = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial link
  qirwc_if.dev link,
  // Array loading
  input wire logic mem_we,
  input wire logic [MEM_AW-1:0] mem_waddr,
  input wire logic [7:0] mem_wdata,
  // Device conditions
  input wire logic quad_lanes_enable_bit,
  input wire logic flash_busy,
  // Status
  output logic wrap_disable_bit,
  output logic [1:0] wrap_length_field,
  output logic continuous_active
);

  // ==========================================================
  // Storage and state
  logic [7:0] mem [2**MEM_AW];
  qirwc_pkg::qirwc_dev_state_t state_q;
  logic sclk_q;
  logic [3:0] cnt_q;
  logic [7:0] cmd_sh_q;
  logic [7:0] cmd_q;
  logic [31:0] sh_q;
  logic ones_q;
  logic [23:0] addr_q;
  logic half_q;
  logic cont_q;
  logic wrap_dis_q;
  logic [1:0] wrap_len_q;
  logic [3:0] lane_o_q;
  logic [3:0] lane_oe_q;

  logic rise;
  logic fall;
  logic cmd_done;
  logic [7:0] cmd_code;
  logic qin_done;
  logic [31:0] qin_word;
  logic mode_reset_seen;
  logic [2:0] dummy_n;
  logic [7:0] rd_byte;

  // ==========================================================
  // Address stepping
  // Aligned section stepping.
  function automatic logic [23:0] qirwc_next_addr(input logic [23:0] a, input logic wrap_on,
                                                  input logic [1:0] len);
    logic [7:0] m;
    logic [7:0] lo;
    m = (`QIRWC_SECTION_MIN << len) - 8'h01;
    lo = a[`QIRWC_PAGE_BITS-1:0] + 8'h01;
    if (wrap_on) begin
      return {a[23:`QIRWC_PAGE_BITS], (a[7:0] & ~m) | (lo & m)};
    end
    return a + 24'h000001;
  endfunction

  function automatic logic qirwc_is_quad_read(input logic [7:0] code);
    return code == `QIRWC_CMD_FAST || code == `QIRWC_CMD_WORD || code == `QIRWC_CMD_OCTAL;
  endfunction

  // ==========================================================
  // Decode
  always_comb begin
    rise = link.sclk & ~sclk_q;
    fall = ~link.sclk & sclk_q;
    cmd_code = {cmd_sh_q[6:0], link.lane[0]};
    cmd_done = !link.cs_n && state_q == qirwc_pkg::DEV_CMD && rise && cnt_q == 4'(`QIRWC_CMD_CLKS - 1);
    qin_word = {sh_q[27:0], link.lane};
    qin_done = !link.cs_n && state_q == qirwc_pkg::DEV_QIN && rise && cnt_q == 4'(`QIRWC_QIN_CLKS - 1);
    mode_reset_seen = cont_q && ones_q && link.lane[0];
    dummy_n = qirwc_pkg::qirwc_dummy_of(cmd_q);
    rd_byte = mem[addr_q[MEM_AW-1:0]];
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'h0;
    end else begin
      sclk_q <= link.sclk;
    end
  end

  // ==========================================================
  // Transaction sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= qirwc_pkg::DEV_IDLE;
      cnt_q <= 4'h0;
      cmd_sh_q <= 8'h00;
      cmd_q <= 8'h00;
      sh_q <= 32'h00000000;
      ones_q <= 1'h1;
      addr_q <= 24'h000000;
      half_q <= 1'h0;
    end else if (link.cs_n) begin
      state_q <= qirwc_pkg::DEV_IDLE;
    end else begin
      unique case (state_q)
        qirwc_pkg::DEV_IDLE: begin
          state_q <= cont_q ? qirwc_pkg::DEV_QIN : qirwc_pkg::DEV_CMD;
          cnt_q <= 4'h0;
          ones_q <= 1'h1;
          half_q <= 1'h0;
        end
        qirwc_pkg::DEV_CMD: begin
          if (rise) begin
            cmd_sh_q <= cmd_code;
            cnt_q <= cnt_q + 4'h1;
          end
          if (cmd_done) begin
            cnt_q <= 4'h0;
            if (cmd_code == `QIRWC_CMD_MODE_RESET || flash_busy) begin
              state_q <= qirwc_pkg::DEV_IGNORE;
            end else if (cmd_code == `QIRWC_CMD_WRAP) begin
              cmd_q <= cmd_code;
              state_q <= qirwc_pkg::DEV_QIN;
            end else if (qirwc_is_quad_read(cmd_code) && quad_lanes_enable_bit) begin
              cmd_q <= cmd_code;
              state_q <= qirwc_pkg::DEV_QIN;
            end else begin
              state_q <= qirwc_pkg::DEV_IGNORE;
            end
          end
        end
        qirwc_pkg::DEV_QIN: begin
          if (rise) begin
            sh_q <= qin_word;
            ones_q <= ones_q & link.lane[0];
            cnt_q <= cnt_q + 4'h1;
          end
          if (qin_done) begin
            cnt_q <= 4'h0;
            if (mode_reset_seen || flash_busy || cmd_q == `QIRWC_CMD_WRAP) begin
              state_q <= qirwc_pkg::DEV_IGNORE;
            end else begin
              addr_q <= qin_word[31:8];
              // Octal read goes straight to data.
              state_q <= (dummy_n == 3'h0) ? qirwc_pkg::DEV_DATA : qirwc_pkg::DEV_DUMMY;
            end
          end
        end
        qirwc_pkg::DEV_DUMMY: begin
          if (rise) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == {1'h0, dummy_n - 3'h1}) begin
              state_q <= qirwc_pkg::DEV_DATA;
            end
          end
        end
        qirwc_pkg::DEV_DATA: begin
          if (fall) begin
            half_q <= ~half_q;
            if (half_q) begin
              addr_q <= qirwc_next_addr(addr_q, !wrap_dis_q && cmd_q != `QIRWC_CMD_OCTAL, wrap_len_q);
            end
          end
        end
        qirwc_pkg::DEV_IGNORE: begin
          state_q <= qirwc_pkg::DEV_IGNORE;
        end
      endcase
    end
  end

  // ==========================================================
  // Continuous read mode
  // A clear from the reset code and a set from a mode byte cannot meet in one
  // cycle, since each belongs to a different transaction.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cont_q <= 1'h0;
    end else if (cmd_done && cmd_code == `QIRWC_CMD_MODE_RESET) begin
      cont_q <= 1'h0;
    end else if (qin_done && mode_reset_seen) begin
      cont_q <= 1'h0;
    end else if (qin_done && !flash_busy && cmd_q != `QIRWC_CMD_WRAP) begin
      cont_q <= qin_word[`QIRWC_CONT_SEL_HI:`QIRWC_CONT_SEL_LO] == `QIRWC_CONT_SEL_ON;
    end
  end

  // ==========================================================
  // Wrap setting
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrap_dis_q <= `QIRWC_WRAP_DIS_RST;
      wrap_len_q <= `QIRWC_WRAP_LEN_RST;
    end else if (qin_done && cmd_q == `QIRWC_CMD_WRAP && !cont_q) begin
      wrap_dis_q <= qin_word[`QIRWC_WRAP_DIS_POS];
      wrap_len_q <= qin_word[`QIRWC_WRAP_LEN_HI:`QIRWC_WRAP_LEN_LO];
    end
  end

  // ==========================================================
  // Lane drivers
  // Data changes on the first ref_clk edge after sclk falls, so the host
  // must hold each low clock phase for at least two ref_clk cycles.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lane_o_q <= 4'h0;
      lane_oe_q <= 4'h0;
    end else if (link.cs_n || state_q != qirwc_pkg::DEV_DATA) begin
      lane_oe_q <= 4'h0;
    end else if (fall) begin
      lane_oe_q <= 4'hF;
      lane_o_q <= half_q ? rd_byte[3:0] : rd_byte[7:4];
    end
  end

  assign link.dev_lane_o = lane_o_q;
  assign link.dev_lane_oe = lane_oe_q;
  assign wrap_disable_bit = wrap_dis_q;
  assign wrap_length_field = wrap_len_q;
  assign continuous_active = cont_q;

endmodule

// *** hw/qirwc_flash_host.sv ***
// Controller end of the quad I/O read link.
// Assumes the flash end shares ref_clk; sclk idles low (mode 0).
`include "qirwc_defs.svh"

module qirwc_flash_host #(
  parameter int HALF_DIV = 4,
  parameter int BYTES_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial link
  qirwc_if.host link,
  // Orders
  input wire logic op_start,
  input wire qirwc_pkg::qirwc_op_t op_kind,
  input wire logic [7:0] op_code,
  input wire logic op_skip_code,
  input wire logic [23:0] op_addr,
  input wire logic [7:0] op_mode,
  input wire logic [7:0] op_wrap_bits,
  input wire logic [BYTES_W-1:0] op_bytes,
  // Results
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic op_done,
  output logic op_busy
);

  // ==========================================================
  // State
  qirwc_pkg::qirwc_host_state_t state_q;
  logic [7:0] div_q;
  logic sclk_q;
  logic cs_n_q;
  logic [BYTES_W+1:0] idx_q;
  logic [BYTES_W+1:0] total_q;
  logic [3:0] ncmd_q;
  logic [2:0] ndum_q;
  logic [7:0] code_q;
  logic [31:0] word_q;
  logic [3:0] lane_o_q;
  logic [3:0] lane_oe_q;
  logic [3:0] rx_q;
  logic rxh_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic done_q;
  logic busy_q;

  logic tick;
  logic [BYTES_W+1:0] sel;
  logic [BYTES_W+1:0] qin_end;
  logic [4:0] nib;
  logic [3:0] nxt_o;
  logic [3:0] nxt_oe;

  // ==========================================================
  // Lane pattern for the clock about to run
  always_comb begin
    tick = div_q == 8'(HALF_DIV - 1);
    sel = (state_q == qirwc_pkg::HOST_SETUP) ? idx_q : idx_q + 1'h1;
    qin_end = (BYTES_W+2)'(ncmd_q) + (BYTES_W+2)'(`QIRWC_QIN_CLKS);
    nib = 5'(sel - (BYTES_W+2)'(ncmd_q));
    nxt_o = 4'h0;
    nxt_oe = 4'h0;
    if (sel < (BYTES_W+2)'(ncmd_q)) begin
      nxt_o = {3'h0, code_q[3'(7 - sel[2:0])]};
      nxt_oe = 4'h1;
    end else if (sel < qin_end) begin
      nxt_o = word_q[5'(28 - {nib[2:0], 2'h0}) +: 4];
      nxt_oe = 4'hF;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= qirwc_pkg::HOST_IDLE;
      div_q <= 8'h00;
      sclk_q <= 1'h0;
      cs_n_q <= 1'h1;
      idx_q <= '0;
      total_q <= '0;
      ncmd_q <= 4'h0;
      ndum_q <= 3'h0;
      code_q <= 8'h00;
      word_q <= 32'h00000000;
      lane_o_q <= 4'h0;
      lane_oe_q <= 4'h0;
      done_q <= 1'h0;
      busy_q <= 1'h0;
    end else begin
      done_q <= 1'h0;
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      unique case (state_q)
        qirwc_pkg::HOST_IDLE: begin
          div_q <= 8'h00;
          if (op_start) begin
            state_q <= qirwc_pkg::HOST_SETUP;
            cs_n_q <= 1'h0;
            busy_q <= 1'h1;
            idx_q <= '0;
            unique case (op_kind)
              qirwc_pkg::OP_READ: begin
                ncmd_q <= op_skip_code ? 4'h0 : 4'(`QIRWC_CMD_CLKS);
                code_q <= op_code;
                word_q <= {op_addr, op_mode};
                ndum_q <= qirwc_pkg::qirwc_dummy_of(op_code);
                total_q <= (BYTES_W+2)'(op_skip_code ? 0 : `QIRWC_CMD_CLKS) + (BYTES_W+2)'(`QIRWC_QIN_CLKS)
                           + (BYTES_W+2)'(qirwc_pkg::qirwc_dummy_of(op_code)) + {1'h0, op_bytes, 1'h0};
              end
              qirwc_pkg::OP_WRAP: begin
                ncmd_q <= 4'(`QIRWC_CMD_CLKS);
                code_q <= `QIRWC_CMD_WRAP;
                word_q <= {24'h000000, op_wrap_bits};
                ndum_q <= 3'h0;
                total_q <= (BYTES_W+2)'(`QIRWC_CMD_CLKS + `QIRWC_QIN_CLKS);
              end
              default: begin
                ncmd_q <= 4'h0;
                code_q <= `QIRWC_CMD_MODE_RESET;
                word_q <= 32'hFFFFFFFF;
                ndum_q <= 3'h0;
                total_q <= (BYTES_W+2)'(`QIRWC_QIN_CLKS);
              end
            endcase
          end
        end
        qirwc_pkg::HOST_SETUP: begin
          lane_o_q <= nxt_o;
          lane_oe_q <= nxt_oe;
          div_q <= 8'h00;
          state_q <= qirwc_pkg::HOST_RUN;
        end
        qirwc_pkg::HOST_RUN: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              idx_q <= idx_q + 1'h1;
              // Next lane pattern set on the falling edge.
              lane_o_q <= nxt_o;
              lane_oe_q <= nxt_oe;
              if (idx_q + 1'h1 == total_q) begin
                state_q <= qirwc_pkg::HOST_GAP;
              end
            end
          end
        end
        qirwc_pkg::HOST_GAP: begin
          if (tick) begin
            cs_n_q <= 1'h1;
            state_q <= qirwc_pkg::HOST_END;
          end
        end
        qirwc_pkg::HOST_END: begin
          if (tick) begin
            done_q <= 1'h1;
            busy_q <= 1'h0;
            state_q <= qirwc_pkg::HOST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Data capture on the rising edge, high nibble first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_q <= 4'h0;
      rxh_q <= 1'h0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'h0;
    end else begin
      rd_valid_q <= 1'h0;
      if (state_q == qirwc_pkg::HOST_IDLE) begin
        rxh_q <= 1'h0;
      end else if (state_q == qirwc_pkg::HOST_RUN && tick && !sclk_q
                   && idx_q >= qin_end + (BYTES_W+2)'(ndum_q)) begin
        rx_q <= link.lane;
        rxh_q <= ~rxh_q;
        if (rxh_q) begin
          rd_data_q <= {rx_q, link.lane};
          rd_valid_q <= 1'h1;
        end
      end
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.host_lane_o = lane_o_q;
  assign link.host_lane_oe = lane_oe_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign op_done = done_q;
  assign op_busy = busy_q;

endmodule

// *** tb/qirwc_link_chk.sv ***
// Checker of the quad read link between the controller and flash ends.
// Assumes both ends share ref_clk and HALF_DIV stays at four cycles.
module qirwc_link_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_lane_oe,
  input wire logic [3:0] dev_lane_o,
  input wire logic [3:0] dev_lane_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Link assertions
  AST_NO_FIGHT: assert property ((host_lane_oe & dev_lane_oe) == 4'h0)
    else $error("host and flash drive one lane together");
  AST_HOST_FREE: assert property ($rose(dev_lane_oe[0]) |-> $past(host_lane_oe) == 4'h0)
    else $error("flash drives before host released lanes");
  AST_LOW_PHASE: assert property ($rose(dev_lane_oe[0]) |-> !sclk && !$past(sclk))
    else $error("flash lanes start outside a low clock phase");
  AST_QUAD_OUT: assert property (dev_lane_oe == 4'h0 || dev_lane_oe == 4'hF)
    else $error("flash drives a partial lane set");
  AST_HOLD_NIBBLE: assert property (sclk && $past(sclk) && $past(dev_lane_oe) == 4'hF |-> $stable(dev_lane_o))
    else $error("flash nibble changes while clock is high");
  AST_QUIET_UNSEL: assert property (cs_n && $past(cs_n) |-> dev_lane_oe == 4'h0)
    else $error("flash drives lanes while deselected");
  AST_CS_SETUP: assert property ($rose(sclk) |-> !cs_n && !$past(cs_n))
    else $error("clock rise without select setup");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4])
    else $error("clock high phase too short");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("clock low phase too short");
  AST_IDLE_CLK: assert property (cs_n |-> !sclk)
    else $error("clock high while deselected");
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the quad read link, both ends as design code.
// Assumes the package, the interface and both ends are compiled first.
`include "qirwc_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, nrst, mem_we, qe, busy, op_start, op_skip, rd_valid, op_done, wdis, cont;
  logic [11:0] mem_waddr;
  logic [7:0] mem_wdata, op_code, op_mode, op_wrap, rd_data;
  logic [1:0] wlen;
  logic op_busy;
  logic [23:0] op_addr;
  logic [15:0] op_bytes, lfsr_q;
  qirwc_pkg::qirwc_op_t op_kind;
  logic [7:0] mem [0:4095];
  logic [7:0] got [$];
  logic [7:0] m_code;
  int fail_count, num_checks, m_dis, m_len, m_cont;

  qirwc_if link ();
  qirwc_flash_dev i_qirwc_flash_dev (.ref_clk(ref_clk), .nrst(nrst), .link(link), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .quad_lanes_enable_bit(qe), .flash_busy(busy),
    .wrap_disable_bit(wdis), .wrap_length_field(wlen), .continuous_active(cont));
  qirwc_flash_host i_qirwc_flash_host (.ref_clk(ref_clk), .nrst(nrst), .link(link), .op_start(op_start),
    .op_kind(op_kind), .op_code(op_code), .op_skip_code(op_skip), .op_addr(op_addr), .op_mode(op_mode),
    .op_wrap_bits(op_wrap), .op_bytes(op_bytes), .rd_data(rd_data), .rd_valid(rd_valid),
    .op_done(op_done), .op_busy(op_busy));
  qirwc_link_chk i_qirwc_link_chk (.ref_clk(ref_clk), .nrst(nrst), .sclk(link.sclk), .cs_n(link.cs_n),
    .host_lane_oe(link.host_lane_oe), .dev_lane_o(link.dev_lane_o), .dev_lane_oe(link.dev_lane_oe));

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int nxt(input int a, input logic [7:0] c);
    int sz;
    sz = 8 << m_len;
    if (m_dis == 0 && c != `QIRWC_CMD_OCTAL) begin
      return (a & ~(sz - 1)) | ((a + 1) & (sz - 1));
    end
    return (a + 1) % 4096;
  endfunction

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic seen);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmps(input string what, input logic [3:0] exp, input logic [3:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_st();
    cmps("status", {m_cont[0], m_dis[0], m_len[1:0]}, {cont, wdis, wlen});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A bound that runs out counts as a mismatch and ends the run at once.
  task automatic do_op(input qirwc_pkg::qirwc_op_t k, input logic [7:0] c, input logic s,
                       input logic [11:0] a, input logic [7:0] m, input logic [7:0] w, input int n);
    int t;
    got.delete();
    op_kind <= k;
    op_code <= c;
    op_skip <= s;
    op_addr <= {12'h000, a};
    op_mode <= m;
    op_wrap <= w;
    op_bytes <= n[15:0];
    op_start <= 1'h1;
    @(posedge ref_clk);
    op_start <= 1'h0;
    @(posedge ref_clk);
    cmp1("busy after start", 1'h1, op_busy);
    t = 0;
    while (op_done !== 1'h1 && t < 9000) begin
      @(posedge ref_clk);
      t++;
      if (rd_valid === 1'h1) begin
        got.push_back(rd_data);
      end
    end
    if (op_done !== 1'h1) begin
      fail_count++;
      print_verdict();
    end
    cmp1("busy after done", 1'h0, op_busy);
  endtask

  task automatic rd(input logic [7:0] c, input logic s, input logic [11:0] a, input logic [7:0] m, input int n);
    logic [7:0] code;
    logic ok;
    int x;
    code = s ? m_code : c;
    do_op(qirwc_pkg::OP_READ, c, s, a, m, 8'h00, n);
    ok = qe === 1'h1 && busy === 1'h0;
    x = int'(a);
    cmp8("byte count", n[7:0], 8'(got.size()));
    for (int i = 0; i < n; i++) begin
      cmp8("read byte", ok ? mem[x] : 8'hFF, got[i]);
      x = nxt(x, code);
    end
    if (ok) begin
      m_code = code;
      m_cont = int'(m[5:4] == 2'b10);
    end
  endtask

  task automatic wrap(input logic d, input logic [1:0] l);
    do_op(qirwc_pkg::OP_WRAP, 8'h00, 1'h0, 12'h000, 8'h00, {1'h0, l, d, 4'hA}, 1);
    m_dis = int'(d);
    m_len = int'(l);
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    #4000000;
    fail_count++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'h0;
    mem_we = 1'h0;
    mem_waddr = 12'h000;
    mem_wdata = 8'h00;
    qe = 1'h1;
    busy = 1'h0;
    op_start = 1'h0;
    op_kind = qirwc_pkg::OP_READ;
    op_code = 8'h00;
    op_skip = 1'h0;
    op_addr = 24'h000000;
    op_mode = 8'h00;
    op_wrap = 8'h00;
    op_bytes = 16'h0000;
    fail_count = 0;
    num_checks = 0;
    lfsr_q = 16'hDE83;
    m_dis = 1;
    m_len = 0;
    m_cont = 0;
    m_code = 8'hEB;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'h1;
    @(posedge ref_clk);
    chk_st();
    for (int i = 0; i < 4096; i++) begin
      lfsr_q = lfsr(lfsr_q);
      mem[i] = lfsr_q[7:0];
      mem_we <= 1'h1;
      mem_waddr <= i[11:0];
      mem_wdata <= lfsr_q[7:0];
      @(posedge ref_clk);
    end
    mem_we <= 1'h0;
    rd(8'hEB, 1'h0, 12'hFFC, 8'h00, 9);
    qe <= 1'h0;
    rd(8'hE7, 1'h0, 12'h00A, 8'h20, 3);
    rd(8'hE3, 1'h0, 12'h010, 8'h20, 3);
    chk_st();
    qe <= 1'h1;
    for (int l = 0; l < 4; l++) begin
      wrap(1'h0, l[1:0]);
      chk_st();
      lfsr_q = lfsr(lfsr_q);
      rd(8'hEB, 1'h0, lfsr_q[11:0], 8'h00, (8 << l) + 3);
      rd(8'hE7, 1'h0, lfsr_q[11:0] & 12'hFFE, 8'h00, (8 << l) + 3);
      rd(8'hE3, 1'h0, lfsr_q[11:0] & 12'hFF0, 8'h00, 20);
    end
    wrap(1'h1, 2'h2);
    chk_st();
    rd(8'hEB, 1'h0, 12'h0FA, 8'h00, 12);
    rd(8'hE7, 1'h0, 12'h100, 8'hA5, 4);
    chk_st();
    rd(8'hE7, 1'h1, 12'h236, 8'h2F, 4);
    busy <= 1'h1;
    rd(8'hE7, 1'h1, 12'h300, 8'h00, 2);
    busy <= 1'h0;
    rd(8'hE7, 1'h1, 12'h310, 8'hD0, 3);
    chk_st();
    rd(8'hE3, 1'h0, 12'h420, 8'h60, 18);
    rd(8'hE3, 1'h1, 12'h530, 8'hE0, 18);
    do_op(qirwc_pkg::OP_MODE_RESET, 8'hFF, 1'h0, 12'h000, 8'h00, 8'h00, 1);
    m_cont = 0;
    chk_st();
    rd(8'hEB, 1'h0, 12'h640, 8'h00, 4);
    print_verdict();
  end
endmodule
